// ===== rtl/spicrc_crc_step.sv
// Purpose: one serial step of the 16-bit checksum, msb first
// Assumes: caller holds the accumulator and feeds one bit per serial clock
// Notes: purely combinational so it can sit in either edge domain
`timescale 1ns/10ps
module spicrc_crc_step (
    input wire logic [15:0] crc_in,
    input wire logic din,
    output logic [15:0] crc_out
);

    // shift left, fold in the generator when the outgoing bit differs from the data bit
    always_comb
    begin
        crc_out = {crc_in[14:0], 1'b0};
        if (crc_in[15] ^ din)
            crc_out = crc_out ^ spicrc_pkg::CRC_POLY;
    end

endmodule : spicrc_crc_step

// ===== rtl/spicrc_engine.sv
// Purpose: serial slave instruction engine reaching registers and message ram
// Assumes: serial mode 0,0 or 1,1; storage answers acc_rdata one clk after acc_req
// Notes: bit logic runs on sck; accesses and end-of-frame actions run on clk
`timescale 1ns/10ps
module spicrc_engine (
    input wire logic clk,
    input wire logic rstn,
    input wire logic sck,
    input wire logic chip_select_n,
    input wire logic sdi,
    output logic sdo,
    output logic sdo_oe,
    output logic acc_req,
    output logic acc_write,
    output logic acc_ram,
    output logic [11:0] acc_addr,
    output logic [31:0] acc_wdata,
    input wire logic [31:0] acc_rdata,
    output logic soft_reset,
    output logic crc_mismatch_flag,
    output logic crc_frame_error_flag,
    output logic [15:0] crc_result
);

    // byte counter value at the start of every frame
    localparam logic [10:0] BYTE_CMD_INIT = spicrc_pkg::BYTE_CMD;

    // sck domain state
    logic live_clr; // select high or reset: the next sck edge opens a new frame
    logic frame_live; // set by the first sck rising edge of a frame
    logic frame_seq; // flips once per frame so clk can tell frames apart
    logic [2:0] bit_cnt; // bits received in the current byte
    logic [10:0] byte_cnt; // whole bytes received, saturating
    logic [7:0] rx_sr; // incoming bits of the current byte
    logic [3:0] cmd; // command nibble of the frame
    logic [11:0] addr; // running burst address
    logic [11:0] start_addr; // header address, kept for verified writes
    logic start_ram; // header address lies in message ram
    logic [7:0] count; // count field of checked commands
    logic [11:0] word_addr; // address of the ram word being assembled
    logic [31:0] word_buf; // incoming word, byte at lowest address in low lane
    logic [15:0] crc; // running checksum
    logic [15:0] crc_rx; // checksum shifted in by the host
    logic [2:0] out_pos; // output bit position, moved on falling edges
    logic rq_tgl_p; // request due, flipped on the rising edge
    logic rq_tgl; // request issued, flipped on the falling edge
    logic rq_write; // request is a write
    logic rq_ram; // request targets ram
    logic [11:0] rq_addr; // request address
    logic [31:0] rq_data; // request write data

    // combinational views of the frame
    logic [2:0] bit_eff;
    logic [10:0] bi;
    logic [15:0] crc_eff;
    logic [7:0] rx_byte;
    logic byte_end;
    logic [11:0] hdr_full;
    logic counted;
    logic limited;
    logic is_rd;
    logic is_wr;
    logic [10:0] hdr_len;
    logic [10:0] data_len;
    logic [10:0] frame_len;
    logic [10:0] di;
    logic [1:0] lane;
    logic in_data;
    logic in_crc;
    logic covered;
    logic crc_bit;
    logic [15:0] next_crc;
    logic [7:0] tx_byte;

    // clk domain state
    logic rq_s1, rq_s2, rq_seen; // request toggle synchroniser
    logic cs_f1, cs_f2, cs_f3, cs_lvl; // select pin synchroniser and filtered level
    logic seq_seen; // frame_seq value of the last frame handled
    logic rd_pend; // read data arrives this cycle
    logic [31:0] rd_hold; // fetched data, shown on sdo
    logic frame_end; // end of a frame that saw sck edges
    logic done; // final checksum byte fully shifted
    logic crc_ok;
    logic checked;
    logic safe_commit;

    assign live_clr = chip_select_n | ~rstn;

    // a frame starts from scratch at its first edge; older values stay for clk to read
    assign bit_eff = frame_live ? bit_cnt : 3'h0;
    assign bi = frame_live ? byte_cnt : spicrc_pkg::BYTE_CMD;
    assign crc_eff = frame_live ? crc : spicrc_pkg::CRC_INIT;
    assign rx_byte = {rx_sr[6:0], sdi};
    assign byte_end = (bit_eff == spicrc_pkg::LAST_BIT);
    assign hdr_full = {addr[11:8], rx_byte};

    // field layout of the current command
    assign counted = (cmd == spicrc_pkg::CMD_WR_CRC) || (cmd == spicrc_pkg::CMD_RD_CRC);
    assign limited = counted || (cmd == spicrc_pkg::CMD_WR_SAFE);
    assign is_rd = (cmd == spicrc_pkg::CMD_READ) || (cmd == spicrc_pkg::CMD_RD_CRC);
    assign is_wr = (cmd == spicrc_pkg::CMD_WRITE) || (cmd == spicrc_pkg::CMD_WR_CRC);
    assign hdr_len = counted ? spicrc_pkg::HDR_COUNTED : spicrc_pkg::HDR_PLAIN;

    // ram counts are words, register counts are bytes
    always_comb
    begin
        if (counted)
            data_len = start_ram ? {1'b0, count, 2'b00} : {3'h0, count};
        else
            data_len = start_ram ? spicrc_pkg::SAFE_RAM_LEN : spicrc_pkg::SAFE_SFR_LEN;
    end

    assign frame_len = hdr_len + data_len;
    assign di = bi - hdr_len;
    assign lane = di[1:0];
    assign in_data = (bi >= hdr_len) && (!limited || (bi < frame_len));
    assign in_crc = limited && (bi >= frame_len) && (bi < (frame_len + spicrc_pkg::CRC_LEN));
    assign covered = !limited || (bi < frame_len);
    assign crc_bit = (is_rd && in_data) ? sdo : sdi;

    spicrc_crc_step u_crc_step (
        .crc_in(crc_eff),
        .din(crc_bit),
        .crc_out(next_crc)
    );

    // frame opener: cleared asynchronously while select is high
    always_ff @(posedge sck or posedge live_clr)
    begin
        if (live_clr)
            frame_live <= 1'b0;
        else
            frame_live <= 1'b1;
    end

    // frame sequence marker
    always_ff @(posedge sck or negedge rstn)
    begin
        if (!rstn)
            frame_seq <= 1'b0;
        else if (!frame_live)
            frame_seq <= ~frame_seq;
    end

    // bit and byte counting, sampled on rising edges
    always_ff @(posedge sck or negedge rstn)
    begin
        if (!rstn)
        begin
            bit_cnt <= 3'h0;
            byte_cnt <= BYTE_CMD_INIT;
            rx_sr <= 8'h00;
        end
        else
        begin
            bit_cnt <= bit_eff + spicrc_pkg::BIT_STEP;
            rx_sr <= rx_byte;
            // saturate so a very long burst never wraps into the header again
            if (byte_end && (bi != spicrc_pkg::BYTE_CNT_MAX))
                byte_cnt <= bi + spicrc_pkg::BYTE_STEP;
            else
                byte_cnt <= bi;
        end
    end

    // header capture and burst address
    always_ff @(posedge sck or negedge rstn)
    begin
        if (!rstn)
        begin
            cmd <= spicrc_pkg::CMD_RESET;
            addr <= spicrc_pkg::ADDR_RESET;
            start_addr <= spicrc_pkg::ADDR_RESET;
            start_ram <= 1'b0;
            count <= 8'h00;
        end
        else if (byte_end)
        begin
            if (bi == spicrc_pkg::BYTE_CMD)
            begin
                cmd <= rx_byte[7:4];
                addr[11:8] <= rx_byte[3:0];
            end
            else if (bi == spicrc_pkg::BYTE_ADDR)
            begin
                addr[7:0] <= rx_byte;
                start_addr <= hdr_full;
                start_ram <= spicrc_pkg::is_ram(hdr_full);
            end
            else if (counted && (bi == spicrc_pkg::BYTE_COUNT))
                count <= rx_byte;
            else if (in_data)
                addr <= spicrc_pkg::next_addr(addr);
        end
    end

    // incoming data assembly for ram words and verified writes
    always_ff @(posedge sck or negedge rstn)
    begin
        if (!rstn)
        begin
            word_buf <= 32'h0000_0000;
            word_addr <= spicrc_pkg::ADDR_RESET;
        end
        else if (byte_end && in_data)
        begin
            word_buf[{lane, 3'h0} +: 8] <= rx_byte;
            if (lane == 2'h0)
                word_addr <= addr;
        end
    end

    // checksum runs alongside the shift register, frozen after the data phase
    always_ff @(posedge sck or negedge rstn)
    begin
        if (!rstn)
        begin
            crc <= spicrc_pkg::CRC_INIT;
            crc_rx <= 16'h0000;
        end
        else
        begin
            crc <= covered ? next_crc : crc_eff;
            if (in_crc)
                crc_rx <= {crc_rx[14:0], sdi};
        end
    end

    // access requests: fields settle on the rising edge, the toggle leaves on the falling one
    always_ff @(posedge sck or negedge rstn)
    begin
        if (!rstn)
        begin
            rq_tgl_p <= 1'b0;
            rq_write <= 1'b0;
            rq_ram <= 1'b0;
            rq_addr <= spicrc_pkg::ADDR_RESET;
            rq_data <= 32'h0000_0000;
        end
        else if (byte_end)
        begin
            if ((bi == spicrc_pkg::BYTE_ADDR) && (cmd == spicrc_pkg::CMD_READ))
            begin
                // first fetch right after the address field
                rq_tgl_p <= ~rq_tgl_p;
                rq_write <= 1'b0;
                rq_ram <= spicrc_pkg::is_ram(hdr_full);
                rq_addr <= hdr_full;
            end
            else if ((bi == spicrc_pkg::BYTE_COUNT) && (cmd == spicrc_pkg::CMD_RD_CRC))
            begin
                // checked reads fetch after the count field instead
                rq_tgl_p <= ~rq_tgl_p;
                rq_write <= 1'b0;
                rq_ram <= start_ram;
                rq_addr <= addr;
            end
            else if (in_data && is_wr && (!start_ram || (lane == spicrc_pkg::WORD_LAST)))
            begin
                // register bytes go one by one, ram only as whole words
                rq_tgl_p <= ~rq_tgl_p;
                rq_write <= 1'b1;
                rq_ram <= start_ram;
                rq_addr <= start_ram ? word_addr : addr;
                rq_data <= start_ram ? {rx_byte, word_buf[23:0]} : {24'h000000, rx_byte};
            end
            else if (in_data && is_rd && (!start_ram || (lane == spicrc_pkg::WORD_LAST))
                     && !(limited && ((bi + spicrc_pkg::BYTE_STEP) >= frame_len)))
            begin
                // look-ahead fetch of the next byte or word
                rq_tgl_p <= ~rq_tgl_p;
                rq_write <= 1'b0;
                rq_ram <= start_ram;
                rq_addr <= spicrc_pkg::next_addr(addr);
            end
        end
    end

    // falling edge: move output bit and release pending requests
    always_ff @(negedge sck or negedge rstn)
    begin
        if (!rstn)
        begin
            out_pos <= 3'h0;
            rq_tgl <= 1'b0;
        end
        else
        begin
            out_pos <= bit_eff;
            rq_tgl <= rq_tgl_p;
        end
    end

    // outgoing byte: fetched data, then the checksum high byte first
    always_comb
    begin
        if (in_crc)
            tx_byte = (bi == frame_len) ? crc[15:8] : crc[7:0];
        else
            tx_byte = rd_hold[{(start_ram ? lane : 2'h0), 3'h0} +: 8];
    end

    assign sdo = (is_rd && (in_data || in_crc)) ? tx_byte[~out_pos] : 1'b0;
    assign sdo_oe = ~chip_select_n;

    // clk side synchronisers: two flops for the request toggle, three for the pin
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            rq_s1 <= 1'b0;
            rq_s2 <= 1'b0;
            cs_f1 <= 1'b1;
            cs_f2 <= 1'b1;
            cs_f3 <= 1'b1;
            cs_lvl <= 1'b1;
        end
        else
        begin
            rq_s1 <= rq_tgl;
            rq_s2 <= rq_s1;
            cs_f1 <= chip_select_n;
            cs_f2 <= cs_f1;
            cs_f3 <= cs_f2;
            if (cs_f2 == cs_f3)
                cs_lvl <= cs_f3;
        end
    end

    // sck is quiet once select is high, so the frame registers are stable to read here
    assign frame_end = (cs_f2 == cs_f3) && cs_f3 && !cs_lvl && (frame_seq != seq_seen);
    assign done = byte_cnt >= (frame_len + spicrc_pkg::CRC_LEN);
    assign crc_ok = (crc == crc_rx);
    assign checked = limited;
    assign safe_commit = frame_end && (cmd == spicrc_pkg::CMD_WR_SAFE) && done && crc_ok;

    // end of frame events
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            seq_seen <= 1'b0;
            soft_reset <= 1'b0;
            crc_mismatch_flag <= 1'b0;
            crc_frame_error_flag <= 1'b0;
            crc_result <= 16'h0000;
        end
        else
        begin
            soft_reset <= 1'b0;
            crc_mismatch_flag <= 1'b0;
            crc_frame_error_flag <= 1'b0;
            if (frame_end)
            begin
                seq_seen <= frame_seq;
                // reset acts only now, at release, and only for an exact two-byte frame
                soft_reset <= (cmd == spicrc_pkg::CMD_RESET) && (start_addr == spicrc_pkg::ADDR_RESET)
                              && (byte_cnt == spicrc_pkg::HDR_PLAIN) && (bit_cnt == 3'h0);
                crc_frame_error_flag <= checked && !done;
                // checked reads never raise a mismatch; the host checks them
                if ((cmd != spicrc_pkg::CMD_RD_CRC) && checked && done && !crc_ok)
                begin
                    crc_mismatch_flag <= 1'b1;
                    crc_result <= crc;
                end
            end
        end
    end

    // access port: sck requests, or a verified write once its checksum matched
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            rq_seen <= 1'b0;
            acc_req <= 1'b0;
            acc_write <= 1'b0;
            acc_ram <= 1'b0;
            acc_addr <= spicrc_pkg::ADDR_RESET;
            acc_wdata <= 32'h0000_0000;
        end
        else
        begin
            acc_req <= 1'b0;
            if (rq_s2 != rq_seen)
            begin
                rq_seen <= rq_s2;
                acc_req <= 1'b1;
                acc_write <= rq_write;
                acc_ram <= rq_ram;
                acc_addr <= rq_addr;
                acc_wdata <= rq_data;
            end
            else if (safe_commit)
            begin
                acc_req <= 1'b1;
                acc_write <= 1'b1;
                acc_ram <= start_ram;
                acc_addr <= start_addr;
                acc_wdata <= start_ram ? word_buf : {24'h000000, word_buf[7:0]};
            end
        end
    end

    // fetched data lands in rd_hold two cycles after the request
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            rd_pend <= 1'b0;
            rd_hold <= 32'h0000_0000;
        end
        else
        begin
            rd_pend <= acc_req && !acc_write;
            if (rd_pend)
                rd_hold <= acc_rdata;
        end
    end

    // checks on the link side
    chk_sfr_wrap: assert property (@(posedge sck) disable iff (!rstn)
        byte_end && in_data && (addr == spicrc_pkg::SFR_HIGH_TOP)
        |=> addr == spicrc_pkg::SFR_HIGH_BASE) else $error("register burst did not wrap");
    chk_ram_wrap: assert property (@(posedge sck) disable iff (!rstn)
        byte_end && in_data && (addr == spicrc_pkg::RAM_TOP)
        |=> addr == spicrc_pkg::RAM_BASE) else $error("ram burst did not wrap");
    chk_frame_start: assert property (@(posedge sck) disable iff (!rstn)
        !frame_live |=> (bit_cnt == 3'h1) && (byte_cnt == BYTE_CMD_INIT)) else $error("frame did not restart");

    // checks on the system side
    chk_reset_single: assert property (@(posedge clk) disable iff (!rstn)
        soft_reset |-> $past(frame_end) ##1 !soft_reset) else $error("reset pulse wrong");
    chk_mismatch_value: assert property (@(posedge clk) disable iff (!rstn)
        crc_mismatch_flag |-> (crc_result != crc_rx) && $past(done)) else $error("bad mismatch capture");
    chk_no_read_flag: assert property (@(posedge clk) disable iff (!rstn)
        crc_mismatch_flag |-> cmd != spicrc_pkg::CMD_RD_CRC) else $error("mismatch on checked read");
    chk_frame_error: assert property (@(posedge clk) disable iff (!rstn)
        crc_frame_error_flag |-> $past(checked) && !$past(done)) else $error("false frame error");
    chk_safe_gate: assert property (@(posedge clk) disable iff (!rstn)
        acc_req && $past(safe_commit) |-> acc_write && (acc_addr == start_addr) && crc_ok)
        else $error("verified write without match");
    chk_rd_capture: assert property (@(posedge clk) disable iff (!rstn)
        acc_req && !acc_write |-> ##2 rd_hold == $past(acc_rdata)) else $error("read data lost");
    chk_ram_decode: assert property (@(posedge clk) disable iff (!rstn)
        acc_req && acc_ram |-> spicrc_pkg::is_ram(acc_addr)) else $error("ram access outside window");

    cov_soft_reset: cover property (@(posedge clk) disable iff (!rstn) soft_reset);
    cov_mismatch: cover property (@(posedge clk) disable iff (!rstn) crc_mismatch_flag);
    cov_frame_error: cover property (@(posedge clk) disable iff (!rstn) crc_frame_error_flag);
    cov_safe_commit: cover property (@(posedge clk) disable iff (!rstn) safe_commit);

endmodule : spicrc_engine

// ===== rtl/spicrc_pkg.sv
// Purpose: shared constants for the serial instruction engine with checksum
// Assumes: 12-bit address space, 4-bit command nibble, byte-wide serial shifting
// Notes: address decode and burst rollover helpers live here so one place owns them
package spicrc_pkg;

    // command nibbles
    localparam logic [3:0] CMD_RESET = 4'h0;
    localparam logic [3:0] CMD_WRITE = 4'h2;
    localparam logic [3:0] CMD_READ = 4'h3;
    localparam logic [3:0] CMD_WR_CRC = 4'ha;
    localparam logic [3:0] CMD_RD_CRC = 4'hb;
    localparam logic [3:0] CMD_WR_SAFE = 4'hc;

    // address map and rollover points
    localparam logic [11:0] ADDR_RESET = 12'h000;
    localparam logic [11:0] SFR_LOW_TOP = 12'h3ff;
    localparam logic [11:0] SFR_LOW_BASE = 12'h000;
    localparam logic [11:0] SFR_HIGH_TOP = 12'hfff;
    localparam logic [11:0] SFR_HIGH_BASE = 12'he00;
    localparam logic [11:0] RAM_BASE = 12'h400;
    localparam logic [11:0] RAM_TOP = 12'hbff;
    localparam logic [11:0] ADDR_STEP = 12'h001;

    // checksum
    localparam logic [15:0] CRC_INIT = 16'hffff;
    localparam logic [15:0] CRC_POLY = 16'h8005;

    // frame geometry, counted in bits, byte lanes and bytes
    localparam logic [2:0] LAST_BIT = 3'h7;
    localparam logic [2:0] BIT_STEP = 3'h1;
    localparam logic [1:0] WORD_LAST = 2'h3;
    localparam logic [10:0] BYTE_CMD = 11'h000;
    localparam logic [10:0] BYTE_ADDR = 11'h001;
    localparam logic [10:0] BYTE_COUNT = 11'h002;
    localparam logic [10:0] HDR_PLAIN = 11'h002;
    localparam logic [10:0] HDR_COUNTED = 11'h003;
    localparam logic [10:0] SAFE_SFR_LEN = 11'h001;
    localparam logic [10:0] SAFE_RAM_LEN = 11'h004;
    localparam logic [10:0] CRC_LEN = 11'h002;
    localparam logic [10:0] BYTE_STEP = 11'h001;
    localparam logic [10:0] BYTE_CNT_MAX = 11'h7ff;

    // message ram window decode
    function automatic logic is_ram(input logic [11:0] a);
        is_ram = (a >= RAM_BASE) && (a <= RAM_TOP);
    endfunction : is_ram

    // burst address advance with region rollover
    function automatic logic [11:0] next_addr(input logic [11:0] a);
        if (a == RAM_TOP)
            next_addr = RAM_BASE;
        else if (a == SFR_LOW_TOP)
            next_addr = SFR_LOW_BASE;
        else if (a == SFR_HIGH_TOP)
            next_addr = SFR_HIGH_BASE;
        else
            next_addr = a + ADDR_STEP;
    endfunction : next_addr

endpackage : spicrc_pkg

// ===== test/spicrc_host.sv
// Purpose: serial master model for the instruction engine
// Assumes: mode 0,0, sck idle low between frames
// Notes: sdi toggles once released so stale bits never look valid
`timescale 1ns/10ps
module spicrc_host (
    output logic sck,
    output logic chip_select_n,
    output logic sdi,
    input wire logic sdo
);
    byte unsigned rx[$]; // bytes captured from sdo
    initial
    begin
        sck = 1'b0;
        chip_select_n = 1'b1;
        sdi = 1'b0;
    end
    // one instruction per select low period, msb first, gap lets fetches land
    task automatic frame(input byte unsigned tx[$], input int gap);
        byte unsigned b;
        rx = {};
        chip_select_n = 1'b0;
        #40;
        foreach (tx[i])
        begin
            for (int k = 7; k >= 0; k--)
            begin
                sdi = tx[i][k];
                #40 sck = 1'b1;
                b = {b[6:0], sdo};
                #40 sck = 1'b0;
            end
            rx.push_back(b);
            sdi = ~sdi;
            if (gap > 0 && i >= 1)
                #(gap);
        end
        #80 chip_select_n = 1'b1;
        sdi = ~sdi;
        #800;
    endtask : frame
endmodule : spicrc_host

// ===== test/test_spi_register_ram_access_crc.sv
// Purpose: self-checking bench for the instruction engine
// Assumes: storage answers acc_rdata with a held word
// Notes: every storage write and end event is matched against a note queue
`timescale 1ns/10ps
`define CHK(n, e, g) begin n_checks++; if ((g) !== (e)) begin error_cnt++; \
    $display("CHECK FAILED %s expected %h seen %h", n, e, g); end end
module test_spi_register_ram_access_crc;
    logic clk, rstn, sck, chip_select_n, sdi, sdo, sdo_oe, acc_req, acc_write, acc_ram;
    logic soft_reset, crc_mismatch_flag, crc_frame_error_flag;
    logic [11:0] acc_addr;
    logic [31:0] acc_wdata, acc_rdata, w;
    logic [15:0] crc_result, c;
    logic [45:0] notes[$], got, exp; // {event, ram, addr, data}
    byte unsigned f[$];
    int error_cnt, n_checks, cyc;
    spicrc_engine i_dut (.clk(clk), .rstn(rstn), .sck(sck), .chip_select_n(chip_select_n),
        .sdi(sdi), .sdo(sdo), .sdo_oe(sdo_oe), .acc_req(acc_req), .acc_write(acc_write),
        .acc_ram(acc_ram), .acc_addr(acc_addr), .acc_wdata(acc_wdata), .acc_rdata(acc_rdata),
        .soft_reset(soft_reset), .crc_mismatch_flag(crc_mismatch_flag),
        .crc_frame_error_flag(crc_frame_error_flag), .crc_result(crc_result));
    spicrc_host i_host (.sck(sck), .chip_select_n(chip_select_n), .sdi(sdi), .sdo(sdo));
    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    // reference checksum, msb first, no reflection
    function automatic logic [15:0] crc16(input byte unsigned q[$]);
        logic [15:0] r;
        r = 16'hffff;
        foreach (q[i])
            for (int k = 7; k >= 0; k--)
                r = {r[14:0], 1'b0} ^ ((r[15] ^ q[i][k]) ? 16'h8005 : 16'h0000);
        return r;
    endfunction : crc16
    task automatic results;
        if (error_cnt == 0 && n_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : results
    // watcher: each write or end event takes the oldest note
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            error_cnt++;
            results();
        end
        if ((acc_req && acc_write) || soft_reset || crc_mismatch_flag || crc_frame_error_flag)
        begin
            got = acc_req ? {1'b0, acc_ram, acc_addr, acc_wdata}
                : {1'b1, 42'h0, soft_reset, crc_mismatch_flag, crc_frame_error_flag};
            exp = (notes.size() > 0) ? notes.pop_front() : '1;
            `CHK("event", exp, got)
        end
    end
    initial
    begin
        rstn = 1'b0;
        acc_rdata = 32'h0;
        void'($urandom(34));
        repeat (4) @(negedge clk);
        rstn = 1'b1;
        repeat (4) @(negedge clk);
        w = $urandom();
        // register burst crossing the low wrap point
        notes.push_back({2'b00, 12'h3ff, 24'h0, w[7:0]});
        notes.push_back({2'b00, 12'h000, 24'h0, w[15:8]});
        f = {8'h23, 8'hff, w[7:0], w[15:8]};
        i_host.frame(f, 0);
        // ram burst over the top, trailing partial word must vanish
        notes.push_back({2'b01, 12'hbfc, w});
        notes.push_back({2'b01, 12'h400, ~w});
        f = {8'h2b, 8'hfc, w[7:0], w[15:8], w[23:16], w[31:24]};
        f = {f, ~w[7:0], ~w[15:8], ~w[23:16], ~w[31:24], 8'h11, 8'h22};
        i_host.frame(f, 0);
        // verified register write, good then corrupted checksum
        f = {8'hc0, 8'h10, w[23:16]};
        c = crc16(f);
        notes.push_back({2'b00, 12'h010, 24'h0, w[23:16]});
        i_host.frame({f, c[15:8], c[7:0]}, 0);
        notes.push_back({1'b1, 42'h0, 3'b010});
        i_host.frame({f, c[15:8], ~c[7:0]}, 0);
        `CHK("crc_result", c, crc_result)
        // checked write cut before its checksum
        notes.push_back({2'b00, 12'h020, 24'h0, w[31:24]});
        notes.push_back({1'b1, 42'h0, 3'b001});
        i_host.frame({8'ha0, 8'h20, 8'h01, w[31:24]}, 0);
        // reset instruction acts only at release
        notes.push_back({1'b1, 42'h0, 3'b100});
        i_host.frame({8'h00, 8'h00}, 0);
        // register read with fetch pauses
        @(negedge clk);
        acc_rdata = ~w;
        i_host.frame({8'h30, 8'h55, 8'h00}, 900);
        `CHK("read_byte", ~w[7:0], i_host.rx[2])
        `CHK("sdo_oe", 1'b0, sdo_oe)
        repeat (20) @(negedge clk);
        `CHK("pending", 0, notes.size())
        results();
    end
endmodule : test_spi_register_ram_access_crc
